// ==== src/line_status_map.svh ====
`ifndef LINE_STATUS_MAP_SVH
`define LINE_STATUS_MAP_SVH
// register select codes on the 3-bit peripheral address
`define LS_ADDR_RECEIVE_HOLDING 3'h0
`define LS_ADDR_LINE_STATUS 3'h5
// status bit positions
`define LS_BIT_FIFO_ERROR 7
`define LS_BIT_TX_EMPTY 6
`define LS_BIT_HOLD_EMPTY 5
`define LS_BIT_BREAK 4
`define LS_BIT_FRAMING 3
`define LS_BIT_PARITY 2
`define LS_BIT_OVERRUN 1
`define LS_BIT_DATA_READY 0
// defaults
`define LS_RESET_OVERRUN 1'h0
`define LS_FIFO_DEPTH 64
`endif

// ==== src/line_status_pkg.sv ====
package line_status_pkg;
   // per-character receive flags stored beside each byte
   typedef struct packed {
      logic break_flag;
      logic framing_flag;
      logic parity_flag;
   } char_flags_t;
endpackage

// ==== src/rx_char_mem.sv ====
`timescale 1ns/1ps
// receive character storage; read data registered
module rx_char_mem #(
   parameter int WIDTH = 11,
   parameter int AW = 6
) (
   input wire logic clock,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [0:(1<<AW)-1];

   // write port
   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // registered read, head entry follows the pointer one cycle later
   always_ff @(posedge clock) begin
      rd_data <= mem[rd_addr];
   end
endmodule

// ==== src/error_counter.sv ====
`timescale 1ns/1ps
// counts flagged characters resident in the receive fifo
module error_counter #(
   parameter int CW = 7
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clear,
   input wire logic inc,
   input wire logic dec,
   output logic any
);
   logic [CW-1:0] count_r;

   // simultaneous push and pop of flagged chars cancel out
   always_ff @(posedge clock) begin
      if (!rst_b || clear) begin
         count_r <= '0;
      end else if (inc && !dec) begin
         count_r <= count_r + CW'(1);
      end else if (dec && !inc && count_r != '0) begin
         count_r <= count_r - CW'(1);
      end
   end

   assign any = (count_r != '0);
endmodule

// ==== src/uart_line_status_logic.sv ====
`timescale 1ns/1ps
`include "line_status_map.svh"
//
// Operation
// R1: bit 7 high while any flagged character sits in receive fifo
// R2: bit 6 high only when holding and shift registers both empty
// R3: bit 5 high when holding register empty; 64 bytes may follow
// R4: bit 4 reports break of current character; byte stored as 00
// R5: bit 3 reports framing error of the head character
// R6: bit 2 reports parity error of the head character
// R7: bit 1 high after a receive overrun occurred
// R8: bit 0 high while receive fifo holds at least one character
// R9: bits 4..2 show head character flags, not history
// R10: bits 4..2 driven from fifo head entry, or from a registered copy of a word written onto the head slot
// R11: status read leaves fifo read pointer unchanged
// R12: read pointer advances only on receive holding read
// R13: host reads status first, then receive holding, to pair flags
// R14: error, flag, overrun and data bits read 0 after reset
// R15: fifos run only when fifo enable bit is 1
// R16: overrun set on char arriving into full fifo, cleared by status read
module uart_line_status_logic
   import line_status_pkg::*;
#(
   parameter int DEPTH = `LS_FIFO_DEPTH,
   parameter int AW = $clog2(`LS_FIFO_DEPTH)
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [2:0] addr,
   input wire logic rd_strobe,
   output logic [7:0] rd_data,
   input wire logic fifo_enable_bit,
   input wire logic rx_fifo_reset,
   input wire logic rx_char_valid,
   input wire logic [7:0] rx_char_data,
   input wire logic rx_char_break,
   input wire logic rx_char_framing,
   input wire logic rx_char_parity,
   input wire logic transmit_holding_empty,
   input wire logic transmit_shift_empty
);
   localparam int W = 11;
   localparam int CW = AW + 1;
   localparam int CAP_W = AW + 1;

   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [CW-1:0] fill_r;
   logic overrun_r;
   logic [W-1:0] head;
   logic [W-1:0] wr_word;
   logic [CAP_W-1:0] cap;
   logic full;
   logic empty;
   logic push;
   logic pop;
   logic holding_read;
   logic status_read;
   logic push_flagged;
   logic pop_flagged;
   logic any_err;
   logic [AW-1:0] rd_addr_mux;
   char_flags_t in_flags;
   char_flags_t head_flags;

   // decode of the peripheral read strobe
   function automatic logic sel(input logic [2:0] a, input logic [2:0] code);
      sel = (a == code);
   endfunction

   assign holding_read = rd_strobe && sel(addr, `LS_ADDR_RECEIVE_HOLDING);
   assign status_read = rd_strobe && sel(addr, `LS_ADDR_LINE_STATUS);

   // fifo disabled shrinks storage to a single holding byte
   assign cap = fifo_enable_bit ? CAP_W'(DEPTH) : CAP_W'(1); // R15
   assign full = (CAP_W'(fill_r) >= cap);
   assign empty = (fill_r == '0);
   assign push = rx_char_valid && !full; // R16
   assign pop = holding_read && !empty; // R12

   // break character forced to zero before storage
   assign in_flags.break_flag = rx_char_break;
   assign in_flags.framing_flag = rx_char_framing;
   assign in_flags.parity_flag = rx_char_parity;
   assign wr_word = {in_flags, rx_char_break ? 8'h00 : rx_char_data}; // R4

   // look ahead so the registered head tracks pointer updates
   assign rd_addr_mux = pop ? rd_ptr_r + AW'(1) : rd_ptr_r; // R11

   rx_char_mem #(
      .WIDTH(W),
      .AW(AW)
   ) u_mem (
      .clock(clock),
      .wr_en(push),
      .wr_addr(wr_ptr_r),
      .wr_data(wr_word),
      .rd_addr(rd_addr_mux),
      .rd_data(head)
   );

   // pointers; only a receive holding read advances the read side, fifo reset clears both
   always_ff @(posedge clock) begin
      if (!rst_b || rx_fifo_reset) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + AW'(1);
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + AW'(1); // R12 R11
         end
      end
   end

   // fill level
   always_ff @(posedge clock) begin
      if (!rst_b || rx_fifo_reset) begin
         fill_r <= '0; // R14
      end else if (push && !pop) begin
         fill_r <= fill_r + CW'(1);
      end else if (pop && !push) begin
         fill_r <= fill_r - CW'(1);
      end
   end

   // overrun: new arrival wins over the clearing status read
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         overrun_r <= `LS_RESET_OVERRUN; // R14
      end else if (rx_char_valid && full) begin
         overrun_r <= 1'b1; // R7 R16
      end else if (status_read) begin
         overrun_r <= 1'b0; // R16
      end
   end

   // a write landing on the head slot makes the memory read stale,
   // so when the written slot is the next head take the flags from the incoming word
   logic bypass_r;
   logic [W-1:0] bypass_word_r;
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         bypass_r <= 1'b0;
         bypass_word_r <= '0;
      end else begin
         bypass_r <= push && (wr_ptr_r == rd_addr_mux);
         bypass_word_r <= wr_word;
      end
   end

   assign head_flags = bypass_r ? char_flags_t'(bypass_word_r[W-1:8])
                                : char_flags_t'(head[W-1:8]);

   assign push_flagged = push && (|in_flags);
   assign pop_flagged = pop && (|head_flags);

   error_counter #(
      .CW(CW)
   ) u_err (
      .clock(clock),
      .rst_b(rst_b),
      .clear(rx_fifo_reset),
      .inc(push_flagged),
      .dec(pop_flagged),
      .any(any_err)
   );

   // read data assembled combinationally; flags come from fifo head
   always_comb begin
      rd_data = 8'h00;
      if (status_read) begin
         rd_data[`LS_BIT_FIFO_ERROR] = any_err; // R1
         rd_data[`LS_BIT_TX_EMPTY] = transmit_holding_empty &&
                                     transmit_shift_empty; // R2
         rd_data[`LS_BIT_HOLD_EMPTY] = transmit_holding_empty; // R3
         rd_data[`LS_BIT_BREAK] = !empty && head_flags.break_flag; // R4 R10
         rd_data[`LS_BIT_FRAMING] = !empty && head_flags.framing_flag; // R5
         rd_data[`LS_BIT_PARITY] = !empty && head_flags.parity_flag; // R6 R9
         rd_data[`LS_BIT_OVERRUN] = overrun_r; // R7
         rd_data[`LS_BIT_DATA_READY] = !empty; // R8
      end else if (holding_read) begin
         // host pairs flags with this byte by reading status first
         rd_data = bypass_r ? bypass_word_r[7:0] : head[7:0]; // R13
      end
   end
endmodule

// ==== tb/line_status_asserts.sv ====
`timescale 1ns/1ps
`include "line_status_map.svh"
module line_status_asserts (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [2:0] addr,
   input wire logic rd_strobe,
   input wire logic [7:0] rd_data,
   input wire logic rx_fifo_reset,
   input wire logic rx_char_valid,
   input wire logic transmit_holding_empty,
   input wire logic transmit_shift_empty
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // read kinds, fifo left alone, status bits that a status read must not change
   logic st, rh, q;
   logic [4:0] keep;
   assign st = rd_strobe && addr == `LS_ADDR_LINE_STATUS;
   assign rh = rd_strobe && addr == `LS_ADDR_RECEIVE_HOLDING;
   assign q = !rx_char_valid && !rx_fifo_reset;
   assign keep = {rd_data[7], rd_data[4:2], rd_data[0]};
   a_idle_zero: assert property (!rd_strobe |-> rd_data == 8'h00)
      else $error("read data not zero while idle");
   a_tx_empty: assert property (st |-> rd_data[6] ==
      (transmit_holding_empty && transmit_shift_empty))
      else $error("transmit empty bit wrong");
   a_hold_empty: assert property (
      st |-> rd_data[5] == transmit_holding_empty)
      else $error("holding empty bit wrong");
   a_after_reset: assert property ($past(!rst_b) && st |->
      rd_data[4:0] == 5'h00 && !rd_data[7])
      else $error("status not clear after reset");
   a_error_summary: assert property (st && |rd_data[4:2] |-> rd_data[7])
      else $error("summary error bit missing");
   a_empty_clean: assert property (st && !rd_data[0] |->
      !rd_data[7] && rd_data[4:2] == 3'h0)
      else $error("flags shown with empty fifo");
   a_break_zero: assert property (st && rd_data[4] && q ##1
      !rd_strobe && q ##1 rh |-> rd_data == 8'h00)
      else $error("break byte not zero");
   a_repeat_same: assert property (st && q ##1 !rd_strobe && q ##1 st
      |-> keep == $past(keep, 2))
      else $error("repeated status read differs");
   a_overrun_clr: assert property (st && q ##1 !rd_strobe && q ##1 st
      |-> !rd_data[1])
      else $error("overrun not cleared by read");
endmodule
bind uart_line_status_logic line_status_asserts chk (.clock, .rst_b,
   .addr, .rd_strobe, .rd_data, .rx_fifo_reset, .rx_char_valid,
   .transmit_holding_empty, .transmit_shift_empty);

// ==== tb/host_bus_model.sv ====
`timescale 1ns/1ps
// host side of the read bus
module host_bus_model (
   input wire logic clock,
   output logic [2:0] addr,
   output logic rd_strobe,
   input wire logic [7:0] rd_data
);
   initial begin
      addr = 3'h0;
      rd_strobe = 1'b0;
   end
   // data is combinational, so take it settled just before the edge
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(negedge clock);
      addr = a;
      rd_strobe = 1'b1;
      #2 d = rd_data;
      @(negedge clock);
      rd_strobe = 1'b0;
      addr = ~a; // released address shows no stale value
   endtask
endmodule

// ==== tb/uart_line_status_logic_tb_top.sv ====
`timescale 1ns/1ps
module uart_line_status_logic_tb_top;
   localparam logic [2:0] ls = 3'h5;
   localparam logic [2:0] rh = 3'h0;
   logic clock, rst_b, fifo_enable_bit, rx_fifo_reset, rx_char_valid;
   logic rx_char_break, rx_char_framing, rx_char_parity, rd_strobe;
   logic transmit_holding_empty, transmit_shift_empty;
   logic [2:0] addr;
   logic [7:0] rd_data, rx_char_data, d;
   int n_mismatch, samples_checked, cycles;
   uart_line_status_logic dut (.clock, .rst_b, .addr, .rd_strobe,
      .rd_data, .fifo_enable_bit, .rx_fifo_reset, .rx_char_valid,
      .rx_char_data, .rx_char_break, .rx_char_framing, .rx_char_parity,
      .transmit_holding_empty, .transmit_shift_empty);
   host_bus_model host (.clock, .addr, .rd_strobe, .rd_data);
   always #2.5 clock = ~clock;
   // hang guard, runs need under a hundred cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // one received character with flags {break, framing, parity}
   task push(input logic [7:0] b, input logic [2:0] f);
      @(negedge clock);
      rx_char_valid = 1'b1;
      rx_char_data = b;
      {rx_char_break, rx_char_framing, rx_char_parity} = f;
      @(negedge clock);
      rx_char_valid = 1'b0;
   endtask
   task t_reset;
      host.rd(ls, d);
      chk(d, 8'h20);
      transmit_shift_empty = 1'b1;
      host.rd(ls, d);
      chk(d, 8'h60);
      transmit_holding_empty = 1'b0;
      host.rd(ls, d);
      chk(d, 8'h00);
      transmit_holding_empty = 1'b1;
   endtask
   // status first, then holding register, pairs flags with bytes
   task t_fifo;
      push(8'h5A, 3'b001);
      push(8'hC3, 3'b010);
      host.rd(ls, d);
      chk(d, 8'hE5);
      host.rd(ls, d);
      chk(d, 8'hE5);
      host.rd(rh, d);
      chk(d, 8'h5A);
      host.rd(ls, d);
      chk(d, 8'hE9);
      host.rd(rh, d);
      chk(d, 8'hC3);
      host.rd(ls, d);
      chk(d, 8'h60);
   endtask
   task t_break;
      push(8'h11, 3'b000);
      push(8'h77, 3'b100);
      host.rd(ls, d);
      chk(d, 8'hE1);
      host.rd(rh, d);
      chk(d, 8'h11);
      host.rd(ls, d);
      chk(d, 8'hF1);
      host.rd(rh, d);
      chk(d, 8'h00);
      host.rd(ls, d);
      chk(d, 8'h60);
   endtask
   // single byte holding: second char is dropped, flush keeps overrun
   task t_overrun;
      fifo_enable_bit = 1'b0;
      push(8'hA1, 3'b000);
      push(8'hB2, 3'b000);
      host.rd(rh, d);
      chk(d, 8'hA1);
      push(8'hC3, 3'b000);
      rx_fifo_reset = 1'b1;
      @(negedge clock);
      rx_fifo_reset = 1'b0;
      host.rd(ls, d);
      chk(d, 8'h62);
      host.rd(ls, d);
      chk(d, 8'h60);
      fifo_enable_bit = 1'b1;
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      {clock, rst_b, rx_fifo_reset, rx_char_valid, rx_char_data} = 0;
      {rx_char_break, rx_char_framing, rx_char_parity} = 3'h0;
      {fifo_enable_bit, transmit_holding_empty} = 2'h3;
      transmit_shift_empty = 1'b0;
      repeat (12) @(negedge clock);
      rst_b = 1'b1;
      t_reset();
      t_fifo();
      t_break();
      t_overrun();
      print_verdict();
   end
endmodule
